// >>> include/sbc_pkg.sv
// Constants and types of the secondary bridge control block
package sbc_pkg;
    localparam int SBC_DW = 32;
    localparam int SBC_IDX_LSB = 2;
    localparam int SBC_IDX_MSB = 9;
    localparam logic [21:0] SBC_ADDR_HI_ZERO = 22'h0;
    localparam logic [1:0] SBC_ADDR_LO_ZERO = 2'h0;
    localparam logic [7:0] SBC_IDX_CMD = 8'h01;
    localparam logic [7:0] SBC_IDX_BCTRL = 8'h3e;
    localparam logic [7:0] SBC_IDX_IRQ_STAT = 8'h50;
    localparam logic [7:0] SBC_IDX_IRQ_MASK = 8'h51;
    localparam int SBC_B_FB2B = 7;
    localparam int SBC_B_SRST = 6;
    localparam int SBC_B_MAM = 5;
    localparam int SBC_B_VGA = 3;
    localparam int SBC_B_DIV = 2;
    localparam int SBC_B_SERR = 1;
    localparam int SBC_B_PERR = 0;
    localparam int SBC_CMD_SERR = 8;
    localparam logic [7:0] SBC_BCTRL_RST = 8'h00;
    localparam int SBC_IRQ_W = 3;
    localparam int SBC_IRQ_MABT = 0;
    localparam int SBC_IRQ_PERR = 1;
    localparam int SBC_IRQ_SERR = 2;
    localparam logic [31:0] SBC_VGA_MEM_LO = 32'h000a0000;
    localparam logic [31:0] SBC_VGA_MEM_HI = 32'h000bffff;
    localparam int SBC_IO_MSB = 9;
    localparam int SBC_DIV_LSB = 8;
    localparam logic [9:0] SBC_VGA_IO_A_LO = 10'h3b0;
    localparam logic [9:0] SBC_VGA_IO_A_HI = 10'h3bb;
    localparam logic [9:0] SBC_VGA_IO_B_LO = 10'h3c0;
    localparam logic [9:0] SBC_VGA_IO_B_HI = 10'h3df;
    localparam logic [1:0] SBC_DIV_LOW_QUARTER = 2'h0;
    localparam logic [31:0] SBC_ABORT_DATA = 32'hffffffff;
    localparam logic [1:0] SBC_HTRANS_NONSEQ = 2'h2;
    localparam logic SBC_HRESP_OKAY = 1'h0;
    typedef enum logic [2:0] {
        SBC_PH_IDLE = 3'h1,
        SBC_PH_WAIT = 3'h2,
        SBC_PH_DONE = 3'h4
    } sbc_phase_t;
endpackage

// >>> include/sbc_reg_if.sv
// Register access strobes between the bus slave and the register file
`timescale 1ns/10ps
`default_nettype none
interface sbc_reg_if;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave (output wr, output rd, output idx, output wdata, input rdata);
    modport regs (input wr, input rd, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> core/sbc_route_decode.sv
// Host cycle routing decode for the secondary link
`timescale 1ns/10ps
`default_nettype none
module sbc_route_decode import sbc_pkg::*; (
    input wire logic is_io,
    input wire logic [31:0] addr,
    input wire logic io_window_hit,
    input wire logic mem_window_hit,
    input wire logic legacy_video_routing,
    input wire logic legacy_expansion_io_diversion,
    output logic to_secondary
);
    logic [9:0] low;
    logic vga_mem;
    logic vga_io;
    logic upper_part;

    always_comb
    begin
        low = addr[SBC_IO_MSB:0];
        vga_mem = !is_io && addr >= SBC_VGA_MEM_LO && addr <= SBC_VGA_MEM_HI;
        // Only the low ten bits compare, so every alias matches
        vga_io = is_io && ((low >= SBC_VGA_IO_A_LO && low <= SBC_VGA_IO_A_HI)
            || (low >= SBC_VGA_IO_B_LO && low <= SBC_VGA_IO_B_HI));
        upper_part = low[SBC_IO_MSB:SBC_DIV_LSB] != SBC_DIV_LOW_QUARTER;
        if (legacy_video_routing && (vga_mem || vga_io))
        begin
            to_secondary = 1'b1;
        end
        else if (is_io)
        begin
            // Diversion only narrows the window, never widens it
            to_secondary = io_window_hit && !(legacy_expansion_io_diversion && upper_part);
        end
        else
        begin
            to_secondary = mem_window_hit;
        end
    end
endmodule
`default_nettype wire

// >>> core/sbc_ahb_slave.sv
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/10ps
`default_nettype none
module sbc_ahb_slave import sbc_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    sbc_reg_if.slave rif
);
    typedef struct packed {
        sbc_phase_t ph;
        logic mapped;
        logic write;
        logic [7:0] idx;
        logic [31:0] rdata;
    } sbc_slv_state_t;

    sbc_slv_state_t s;
    sbc_slv_state_t next_s;
    logic take;

    assign take = hsel && htrans == SBC_HTRANS_NONSEQ && hready;

    always_comb
    begin
        next_s = s;
        case (s.ph)
            SBC_PH_IDLE, SBC_PH_DONE:
            begin
                next_s.ph = take ? SBC_PH_WAIT : SBC_PH_IDLE;
                if (take)
                begin
                    // Anything outside the low word map is unmapped: writes drop, reads zero
                    next_s.mapped = haddr[31:SBC_IDX_MSB + 1] == SBC_ADDR_HI_ZERO
                        && haddr[SBC_IDX_LSB - 1:0] == SBC_ADDR_LO_ZERO;
                    next_s.write = hwrite;
                    next_s.idx = haddr[SBC_IDX_MSB:SBC_IDX_LSB];
                end
            end
            SBC_PH_WAIT:
            begin
                next_s.ph = SBC_PH_DONE;
                next_s.rdata = (s.mapped && !s.write) ? rif.rdata : '0;
            end
            default:
            begin
                next_s.ph = SBC_PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s <= '{ph: SBC_PH_IDLE, mapped: 1'b0, write: 1'b0, idx: '0, rdata: '0};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign rif.wr = s.ph == SBC_PH_WAIT && s.write && s.mapped;
    assign rif.rd = s.ph == SBC_PH_WAIT && !s.write && s.mapped;
    assign rif.idx = s.idx;
    assign rif.wdata = hwdata;
    assign hreadyout = s.ph != SBC_PH_WAIT;
    assign hresp = SBC_HRESP_OKAY;
    assign hrdata = s.rdata;
endmodule
`default_nettype wire

// >>> core/sbc_top.sv
// Secondary bridge control: registers, routing, abort and error forwarding
`timescale 1ns/10ps
`default_nettype none
module sbc_top import sbc_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    input wire logic host_req_valid,
    input wire logic host_req_io,
    input wire logic [31:0] host_req_addr,
    input wire logic io_window_hit,
    input wire logic mem_window_hit,
    output logic route_valid,
    output logic route_secondary,
    output logic route_primary,
    input wire logic sec_cpl_valid,
    input wire logic sec_cpl_read,
    input wire logic sec_cpl_abort,
    input wire logic [31:0] sec_cpl_data,
    output logic host_cpl_valid,
    output logic [31:0] host_cpl_data,
    output logic host_cpl_dropped,
    input wire logic sec_serr_in,
    input wire logic sec_parity_err,
    input wire logic other_err,
    output logic pri_serr_msg,
    output logic sec_fast_b2b,
    output logic sec_reset_out
);
    typedef struct packed {
        logic legacy_video_routing;
        logic legacy_expansion_io_diversion;
        logic system_error_forwarding;
        logic parity_response;
        logic cmd_serr_en;
        logic [SBC_IRQ_W-1:0] irq_stat;
        logic [SBC_IRQ_W-1:0] irq_mask;
        logic route_valid;
        logic route_sec;
        logic route_pri;
        logic cpl_valid;
        logic [SBC_DW-1:0] cpl_data;
        logic cpl_dropped;
        logic pri_serr;
    } sbc_top_state_t;

    sbc_top_state_t s;
    sbc_top_state_t next_s;
    sbc_reg_if rif();
    logic dec_sec;
    logic serr_sec;
    logic serr_par;
    logic abort_evt;
    logic [7:0] bctrl_rd;

    sbc_ahb_slave sbc_ahb_slave_i (
        .ref_clk(ref_clk),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rif(rif.slave)
    );

    sbc_route_decode sbc_route_decode_i (
        .is_io(host_req_io),
        .addr(host_req_addr),
        .io_window_hit(io_window_hit),
        .mem_window_hit(mem_window_hit),
        .legacy_video_routing(s.legacy_video_routing),
        .legacy_expansion_io_diversion(s.legacy_expansion_io_diversion),
        .to_secondary(dec_sec)
    );

    // Bits 7..4 stay zero: no fast back-to-back, no reset, fixed abort mode
    always_comb
    begin
        bctrl_rd = SBC_BCTRL_RST;
        bctrl_rd[SBC_B_VGA] = s.legacy_video_routing;
        bctrl_rd[SBC_B_DIV] = s.legacy_expansion_io_diversion;
        bctrl_rd[SBC_B_SERR] = s.system_error_forwarding;
        bctrl_rd[SBC_B_PERR] = s.parity_response;
    end

    always_comb
    begin
        rif.rdata = '0;
        case (rif.idx)
            SBC_IDX_BCTRL:
            begin
                rif.rdata[7:0] = bctrl_rd;
            end
            SBC_IDX_CMD:
            begin
                rif.rdata[SBC_CMD_SERR] = s.cmd_serr_en;
            end
            SBC_IDX_IRQ_STAT:
            begin
                rif.rdata[SBC_IRQ_W-1:0] = s.irq_stat;
            end
            SBC_IDX_IRQ_MASK:
            begin
                rif.rdata[SBC_IRQ_W-1:0] = s.irq_mask;
            end
            default:
            begin
                rif.rdata = '0;
            end
        endcase
    end

    always_comb
    begin
        abort_evt = sec_cpl_valid && sec_cpl_abort;
        serr_sec = sec_serr_in && s.system_error_forwarding;
        // Parity reporting rides on the forwarding bit as well
        serr_par = sec_parity_err && s.parity_response && s.system_error_forwarding;
        next_s = s;
        next_s.route_valid = host_req_valid;
        next_s.route_sec = host_req_valid && dec_sec;
        next_s.route_pri = host_req_valid && !dec_sec;
        next_s.cpl_valid = sec_cpl_valid;
        next_s.cpl_dropped = abort_evt && !sec_cpl_read;
        if (sec_cpl_valid)
        begin
            if (!sec_cpl_read)
            begin
                next_s.cpl_data = '0;
            end
            else if (sec_cpl_abort)
            begin
                next_s.cpl_data = SBC_ABORT_DATA;
            end
            else
            begin
                next_s.cpl_data = sec_cpl_data;
            end
        end
        // Other errors skip the parity gate but not the global enable
        next_s.pri_serr = s.cmd_serr_en && (serr_sec || serr_par || other_err);
        if (rif.wr)
        begin
            case (rif.idx)
                SBC_IDX_BCTRL:
                begin
                    // Only the four writable bits are stored
                    next_s.legacy_video_routing = rif.wdata[SBC_B_VGA];
                    next_s.legacy_expansion_io_diversion = rif.wdata[SBC_B_DIV];
                    next_s.system_error_forwarding = rif.wdata[SBC_B_SERR];
                    next_s.parity_response = rif.wdata[SBC_B_PERR];
                end
                SBC_IDX_CMD:
                begin
                    next_s.cmd_serr_en = rif.wdata[SBC_CMD_SERR];
                end
                SBC_IDX_IRQ_STAT:
                begin
                    next_s.irq_stat = s.irq_stat & ~rif.wdata[SBC_IRQ_W-1:0];
                end
                SBC_IDX_IRQ_MASK:
                begin
                    next_s.irq_mask = rif.wdata[SBC_IRQ_W-1:0];
                end
                default:
                begin
                    next_s.irq_mask = s.irq_mask;
                end
            endcase
        end
        // Sets come after the clear so a same-cycle event survives
        if (abort_evt)
        begin
            next_s.irq_stat[SBC_IRQ_MABT] = 1'b1;
        end
        if (sec_parity_err)
        begin
            next_s.irq_stat[SBC_IRQ_PERR] = 1'b1;
        end
        if (next_s.pri_serr)
        begin
            next_s.irq_stat[SBC_IRQ_SERR] = 1'b1;
        end
    end

    // Zero state is the documented control reset of 00h
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign irq = |(s.irq_stat & s.irq_mask);
    assign route_valid = s.route_valid;
    assign route_secondary = s.route_sec;
    assign route_primary = s.route_pri;
    assign host_cpl_valid = s.cpl_valid;
    assign host_cpl_data = s.cpl_data;
    assign host_cpl_dropped = s.cpl_dropped;
    assign pri_serr_msg = s.pri_serr;
    assign sec_fast_b2b = 1'b0;
    assign sec_reset_out = 1'b0;

    logic [9:0] chk_low;
    logic chk_vga_mem;
    logic chk_vga_io;
    logic chk_upper;
    assign chk_low = host_req_addr[SBC_IO_MSB:0];
    assign chk_vga_mem = !host_req_io && host_req_addr >= SBC_VGA_MEM_LO && host_req_addr <= SBC_VGA_MEM_HI;
    assign chk_vga_io = host_req_io && ((chk_low >= SBC_VGA_IO_A_LO && chk_low <= SBC_VGA_IO_A_HI)
        || (chk_low >= SBC_VGA_IO_B_LO && chk_low <= SBC_VGA_IO_B_HI));
    assign chk_upper = chk_low[SBC_IO_MSB:SBC_DIV_LSB] != SBC_DIV_LOW_QUARTER;

    default clocking sbc_cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    AST_NO_FB2B: assert property (!sec_fast_b2b && !bctrl_rd[SBC_B_FB2B])
        else $error("fast back-to-back seen");
    AST_NO_SEC_RESET: assert property (!sec_reset_out && !bctrl_rd[SBC_B_SRST])
        else $error("secondary reset seen");
    AST_ABORT_READ_ONES: assert property (
        sec_cpl_valid && sec_cpl_abort && sec_cpl_read
        |=> host_cpl_valid && host_cpl_data == SBC_ABORT_DATA && !host_cpl_dropped)
        else $error("abort read not all ones");
    AST_ABORT_WRITE_DROP: assert property (
        sec_cpl_valid && sec_cpl_abort && !sec_cpl_read
        |=> host_cpl_valid && host_cpl_dropped && host_cpl_data == '0)
        else $error("abort write data not dropped");
    AST_VGA_MEM_SEC: assert property (
        host_req_valid && chk_vga_mem && s.legacy_video_routing |=> route_valid && route_secondary)
        else $error("video memory not sent secondary");
    AST_VGA_IO_SEC: assert property (
        host_req_valid && chk_vga_io && s.legacy_video_routing |=> route_secondary && !route_primary)
        else $error("video io not sent secondary");
    AST_VGA_INDEP: assert property (
        host_req_valid && (chk_vga_io || chk_vga_mem) && s.legacy_video_routing
        && s.legacy_expansion_io_diversion && !io_window_hit && !mem_window_hit |=> route_secondary)
        else $error("video routing depends on windows");
    AST_VGA_OFF_PRI: assert property (
        host_req_valid && chk_vga_mem && !s.legacy_video_routing && !mem_window_hit |=> route_primary)
        else $error("video memory sent secondary while off");
    AST_IO_OUTSIDE_PRI: assert property (
        host_req_valid && host_req_io && !io_window_hit && !(s.legacy_video_routing && chk_vga_io)
        |=> route_primary)
        else $error("io outside window sent secondary");
    AST_DIVERT_PRI: assert property (
        host_req_valid && host_req_io && io_window_hit && chk_upper && s.legacy_expansion_io_diversion
        && !(s.legacy_video_routing && chk_vga_io) |=> route_primary)
        else $error("diverted io sent secondary");
    AST_WINDOW_SEC: assert property (
        host_req_valid && host_req_io && io_window_hit && !s.legacy_expansion_io_diversion |=> route_secondary)
        else $error("window io not sent secondary");
    AST_SERR_BLOCK: assert property (
        !s.system_error_forwarding && !other_err |=> !pri_serr_msg)
        else $error("blocked error message forwarded");
    AST_SERR_FWD: assert property (
        sec_serr_in && s.system_error_forwarding && s.cmd_serr_en |=> pri_serr_msg ##0 s.irq_stat[SBC_IRQ_SERR])
        else $error("error message not forwarded");
    AST_PARITY_REPORT: assert property (
        sec_parity_err && s.parity_response && s.system_error_forwarding && s.cmd_serr_en |=> pri_serr_msg)
        else $error("parity error not reported");
    AST_PARITY_QUIET: assert property (
        sec_parity_err && !s.parity_response && !sec_serr_in && !other_err |=> !pri_serr_msg)
        else $error("parity reported while disabled");
    AST_OTHER_ERR: assert property (
        other_err && s.cmd_serr_en && !s.parity_response |=> pri_serr_msg)
        else $error("other error not reported");
    AST_RESET_VALUE: assert property ($fell(rst) |-> bctrl_rd == SBC_BCTRL_RST && !irq)
        else $error("control not cleared after reset");
    AST_GLOBAL_GATE: assert property (!s.cmd_serr_en |=> !pri_serr_msg)
        else $error("error message without global enable");
    AST_FIXED_BITS: assert property (
        rif.wr && rif.idx == SBC_IDX_BCTRL
        |=> bctrl_rd[7:4] == SBC_BCTRL_RST[7:4] ##1 bctrl_rd[7:4] == SBC_BCTRL_RST[7:4])
        else $error("fixed bits took a write");

    COV_VGA_ROUTE: cover property (host_req_valid && chk_vga_mem && s.legacy_video_routing ##1 route_secondary);
    COV_DIVERT: cover property (host_req_valid && host_req_io && io_window_hit && chk_upper
        && s.legacy_expansion_io_diversion ##1 route_primary);
    COV_PARITY: cover property (sec_parity_err ##1 pri_serr_msg ##1 irq);
    COV_ABORT: cover property (sec_cpl_valid && sec_cpl_abort && sec_cpl_read ##1 host_cpl_valid);
    COV_WRITE_DROP: cover property (sec_cpl_valid && sec_cpl_abort && !sec_cpl_read ##1 host_cpl_dropped);
endmodule
`default_nettype wire

// >>> tb/sbc_far_model.sv
// Model of the downstream device on the secondary link
`timescale 1ns/10ps
`default_nettype none
module sbc_far_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic abort,
    input wire logic [3:0] dly,
    input wire logic [31:0] data,
    output logic sec_cpl_valid,
    output logic sec_cpl_read,
    output logic sec_cpl_abort,
    output logic [31:0] sec_cpl_data,
    output logic sec_serr_in,
    output logic sec_parity_err
);
    logic pend;
    logic [3:0] cnt;
    // Kinds: 0 write, 1 read, 2 error message, 3 parity error
    always @(posedge ref_clk)
    begin
        sec_cpl_valid <= 1'b0;
        sec_serr_in <= 1'b0;
        sec_parity_err <= 1'b0;
        // Idle lines wander so a stale value can never pass
        sec_cpl_read <= ~sec_cpl_read;
        sec_cpl_abort <= ~sec_cpl_abort;
        sec_cpl_data <= ~sec_cpl_data;
        if (rst)
        begin
            pend <= 1'b0;
            sec_cpl_read <= 1'b0;
            sec_cpl_abort <= 1'b0;
            sec_cpl_data <= 32'h0;
        end
        else if (go)
        begin
            pend <= 1'b1;
            cnt <= dly;
        end
        else if (pend && cnt != 4'h0)
            cnt <= cnt - 4'h1;
        else if (pend)
        begin
            pend <= 1'b0;
            sec_cpl_valid <= !kind[1];
            sec_cpl_read <= kind[0];
            sec_cpl_abort <= abort;
            sec_cpl_data <= data;
            sec_serr_in <= kind == 2'h2;
            sec_parity_err <= kind == 2'h3;
        end
    end
endmodule
`default_nettype wire

// >>> tb/sbc_top_tb.sv
// Self-checking bench for the secondary bridge control block
`timescale 1ns/10ps
`default_nettype none
module sbc_top_tb import sbc_pkg::*; ();
    localparam logic [31:0] A_CMD = {SBC_ADDR_HI_ZERO, SBC_IDX_CMD, SBC_ADDR_LO_ZERO};
    localparam logic [31:0] A_CTL = {SBC_ADDR_HI_ZERO, SBC_IDX_BCTRL, SBC_ADDR_LO_ZERO};
    localparam logic [31:0] A_STAT = {SBC_ADDR_HI_ZERO, SBC_IDX_IRQ_STAT, SBC_ADDR_LO_ZERO};
    localparam logic [31:0] A_MASK = {SBC_ADDR_HI_ZERO, SBC_IDX_IRQ_MASK, SBC_ADDR_LO_ZERO};
    // {ctl[3:0], io, io_hit, mem_hit, secondary, addr}
    localparam logic [39:0] RT [21] = '{40'h00000a0000, 40'h03000a0000, 40'h08000003c0, 40'h0d00000100,
        40'h81000a0000, 40'h81000bffff, 40'h80000c0000, 40'h800009ffff, 40'h89000003b0, 40'h89000003bb,
        40'h88000003bc, 40'h89000003df, 40'h88000003e0, 40'h890000fbc0, 40'hc9000003c0, 40'h4c00000100,
        40'h4d000000ff, 40'h4d00000400, 40'h48000000ff, 40'h4c000003ff, 40'h43000d0000};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, irq, rv, rs, rp, cv, cr, ca, hcv, drop, serr, par, msg, fb2b, srst;
    logic [31:0] hrdata, cd, hcd, q;
    logic hv = 1'b0;
    logic hio = 1'b0;
    logic iow = 1'b0;
    logic memw = 1'b0;
    logic oth = 1'b0;
    logic go = 1'b0;
    logic ab = 1'b0;
    logic [31:0] ha = 32'h0;
    logic [31:0] pdata = 32'h0;
    logic [1:0] kind = 2'h0;
    logic [3:0] dly = 4'h0;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #20 ref_clk = ~ref_clk;

    sbc_top sbc_top_i (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq(irq), .host_req_valid(hv), .host_req_io(hio),
        .host_req_addr(ha), .io_window_hit(iow), .mem_window_hit(memw), .route_valid(rv),
        .route_secondary(rs), .route_primary(rp), .sec_cpl_valid(cv), .sec_cpl_read(cr),
        .sec_cpl_abort(ca), .sec_cpl_data(cd), .host_cpl_valid(hcv), .host_cpl_data(hcd),
        .host_cpl_dropped(drop), .sec_serr_in(serr), .sec_parity_err(par), .other_err(oth),
        .pri_serr_msg(msg), .sec_fast_b2b(fb2b), .sec_reset_out(srst));
    sbc_far_model sbc_far_model_i (.ref_clk(ref_clk), .rst(rst), .go(go), .kind(kind), .abort(ab),
        .dly(dly), .data(pdata), .sec_cpl_valid(cv), .sec_cpl_read(cr), .sec_cpl_abort(ca),
        .sec_cpl_data(cd), .sec_serr_in(serr), .sec_parity_err(par));

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask

    // Address phase held until ready, then data phase until ready again
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= SBC_HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        q = hrdata;
        cmp_bit(hresp, SBC_HRESP_OKAY);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        cmp_word(q, exp);
    endtask

    task automatic route(input logic io, input logic [31:0] a, input logic iw, input logic mw, input logic exp);
        @(posedge ref_clk);
        hv <= 1'b1;
        hio <= io;
        ha <= a;
        iow <= iw;
        memw <= mw;
        @(posedge ref_clk);
        hv <= 1'b0;
        @(posedge ref_clk);
        cmp_bit(rv, 1'b1);
        cmp_bit(rs, exp);
        cmp_bit(rp, !exp);
    endtask

    task automatic cpl(input logic [1:0] k, input logic a, input logic [3:0] d, input logic [31:0] dat,
        input logic [31:0] expd, input logic expdrop);
        int n;
        n = 0;
        @(posedge ref_clk);
        go <= 1'b1;
        kind <= k;
        ab <= a;
        dly <= d;
        pdata <= dat;
        @(posedge ref_clk);
        go <= 1'b0;
        while (hcv !== 1'b1 && n < 40)
        begin
            @(posedge ref_clk);
            n++;
        end
        cmp_bit(hcv, 1'b1);
        cmp_word(hcd, expd);
        cmp_bit(drop, expdrop);
    endtask

    // Kinds: 0 forwarded message, 1 parity error, 2 other error
    task automatic err(input int k, input logic exp);
        @(posedge ref_clk);
        if (k == 2)
            oth <= 1'b1;
        else
            go <= 1'b1;
        kind <= k[1:0] + 2'h2;
        ab <= 1'b0;
        dly <= 4'h0;
        @(posedge ref_clk);
        oth <= 1'b0;
        go <= 1'b0;
        if (k != 2)
            repeat (2) @(posedge ref_clk);
        @(posedge ref_clk);
        cmp_bit(msg, exp);
    endtask

    task automatic results();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_mismatch++;
        results();
    end

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        cmp_bit(irq, 1'b0);
        rdc(A_CTL, {24'h0, SBC_BCTRL_RST});
        rdc(A_CMD, 32'h0);
        wr(A_CTL, 32'hff);
        rdc(A_CTL, 32'h0f);
        cmp_bit(fb2b, 1'b0);
        cmp_bit(srst, 1'b0);
        wr(32'h400, 32'hff);
        rdc(32'h400, 32'h0);
        wr(A_CTL, 32'h4);
        rdc(A_CTL, 32'h4);
        // Video routing only ever set in this one bridge
        foreach (RT[i])
        begin
            wr(A_CTL, {28'h0, RT[i][39:36]});
            route(RT[i][35], RT[i][31:0], RT[i][34], RT[i][33], RT[i][32]);
        end
        cpl(2'h1, 1'b0, 4'h0, 32'h12345678, 32'h12345678, 1'b0);
        cpl(2'h1, 1'b1, 4'h5, 32'h12345678, SBC_ABORT_DATA, 1'b0);
        cpl(2'h0, 1'b1, 4'h2, 32'h5a5a5a5a, 32'h0, 1'b1);
        cpl(2'h0, 1'b0, 4'h0, 32'h5a5a5a5a, 32'h0, 1'b0);
        rdc(A_STAT, 32'h1);
        cmp_bit(irq, 1'b0);
        wr(A_MASK, 32'h1);
        repeat (2) @(posedge ref_clk);
        cmp_bit(irq, 1'b1);
        wr(A_STAT, 32'h1);
        repeat (2) @(posedge ref_clk);
        cmp_bit(irq, 1'b0);
        rdc(A_STAT, 32'h0);
        for (int c = 0; c < 8; c++)
        begin
            for (int k = 0; k < 3; k++)
            begin
                wr(A_CMD, {23'h0, c[2], 8'h0});
                wr(A_CTL, {30'h0, c[1:0]});
                err(k, c[2] & ((k == 0) & c[1] | (k == 1) & c[1] & c[0] | (k == 2)));
            end
        end
        rdc(A_STAT, 32'h6);
        // Second reset in mid-run must clear what the tests left set
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rdc(A_CTL, 32'h0);
        rdc(A_STAT, 32'h0);
        results();
    end
endmodule
`default_nettype wire
